// ==== hdl/encoder_marker_freeze_capture.sv ====
// Marker and freeze position capture for reference and feedback encoders
//
// Contract
// R1 - Marker captures turns high, coarse low
// R2 - Marker capture word readable, signed 32-bit
// R3 - Marker sets flag only when enabled
// R4 - Software writes zero to re-arm flag
// R5 - Software write of one is ignored
// R6 - Source selector encodes base, slots, user, none
// R7 - Freeze sets flag only when enabled
// R8 - Freeze captures only while flag zero
// R9 - Freeze captures turns high, coarse low
// R10 - Captured words hold until next qualifying event
//
// Design decisions made here: the APB register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none

module encoder_marker_freeze_capture
    import encoder_capture_pkg::*;
(
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [7:0]            paddr,
    input  wire logic [31:0]           pwdata,
    input  wire logic [3:0]            pstrb,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire position_set_s         ref_positions,
    input  wire position_set_s         fb_positions,
    input  wire logic [NUM_CH-1:0]     marker_pulse,
    input  wire logic [NUM_CH-1:0]     freeze_input,
    output logic                       irq
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        channel_s [NUM_CH-1:0] ch;
        logic [IRQ_W-1:0]      irq_status;
        logic [IRQ_W-1:0]      irq_mask;
        apb_resp_s             resp;
        logic                  irq;
    } state_s;

    state_s state;
    state_s next_state;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic position_s select_position(
        input logic [7:0]    sel,
        input position_set_s set
    );
        position_s p;
        p = '0;
        unique case (sel)
            SRC_BASE_ENCODER: p = set.base_encoder; // R6
            SRC_SLOT_1:       p = set.slot_1; // R6
            SRC_SLOT_2:       p = set.slot_2; // R6
            SRC_SLOT_3:       p = set.slot_3; // R6
            SRC_USER_PROGRAM: p = set.user_program; // R6
            // Unconfigured or out of range: frozen at zero
            default:          p = '0; // R6
        endcase
        return p;
    endfunction

    function automatic logic [31:0] pack_word(input position_s p);
        logic [31:0] w;
        w = '0;
        w[TURNS_LSB +: POS_W] = p.turns; // R1 R9
        w[POS_W-1:0]          = p.coarse; // R1 R9
        return w;
    endfunction

    function automatic logic [31:0] byte_merge(
        input logic [31:0] old_value,
        input logic [31:0] wdata,
        input logic [3:0]  strb
    );
        logic [31:0] m;
        m = old_value;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                m[b*8 +: 8] = wdata[b*8 +: 8];
            end
        end
        return m;
    endfunction

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    logic                    wr_en;
    logic                    setup_en;
    logic [NUM_CH-1:0]       marker_edge;
    logic [NUM_CH-1:0]       freeze_edge;
    logic [NUM_CH-1:0]       marker_clear;
    logic [NUM_CH-1:0]       freeze_clear;
    logic [IRQ_W-1:0]        events;
    logic [31:0]             rdata;
    logic [31:0]             mask_word;
    logic                    addr_ok;
    position_s               pos;

    always_comb begin
        next_state   = state;
        wr_en        = psel && penable && pwrite;
        setup_en     = psel && !penable;
        marker_clear = '0;
        freeze_clear = '0;
        events       = '0;
        rdata        = '0;
        mask_word    = '0;
        addr_ok      = 1'b1;
        pos          = '0;

        // Ready follows psel by one cycle, so each transfer completes with no
        // wait state; data and error are loaded in that setup cycle
        next_state.resp.pready = psel;

        // ------------------------------------------------------------------
        // Input synchronisers: two flops, then an edge flop
        // ------------------------------------------------------------------
        for (int c = 0; c < NUM_CH; c++) begin
            next_state.ch[c].marker_sync = {state.ch[c].marker_sync[1:0],
                                            marker_pulse[c]};
            next_state.ch[c].freeze_sync = {state.ch[c].freeze_sync[1:0],
                                            freeze_input[c]};
            marker_edge[c] = state.ch[c].marker_sync[1]
                          && !state.ch[c].marker_sync[2];
            freeze_edge[c] = state.ch[c].freeze_sync[1]
                          && !state.ch[c].freeze_sync[2];
        end

        // ------------------------------------------------------------------
        // Register writes
        // ------------------------------------------------------------------
        if (wr_en) begin
            unique case (paddr)
                ADDR_REF_MARKER_FLAG: begin
                    marker_clear[CH_REF] = pstrb[0] && !pwdata[0]; // R4 R5
                end
                ADDR_FB_MARKER_FLAG: begin
                    marker_clear[CH_FB] = pstrb[0] && !pwdata[0]; // R4 R5
                end
                ADDR_REF_FREEZE_FLAG: begin
                    freeze_clear[CH_REF] = pstrb[0] && !pwdata[0]; // R8
                end
                ADDR_FB_FREEZE_FLAG: begin
                    freeze_clear[CH_FB] = pstrb[0] && !pwdata[0]; // R8
                end
                ADDR_REF_SOURCE_SELECT: begin
                    if (pstrb[0]) begin
                        next_state.ch[CH_REF].source_select = pwdata[7:0];
                    end
                end
                ADDR_FB_SOURCE_SELECT: begin
                    if (pstrb[0]) begin
                        next_state.ch[CH_FB].source_select = pwdata[7:0];
                    end
                end
                ADDR_REF_MARKER_FLAG_ENABLE: begin
                    if (pstrb[0]) begin
                        next_state.ch[CH_REF].marker_flag_enable = pwdata[0];
                    end
                end
                ADDR_FB_MARKER_FLAG_ENABLE: begin
                    if (pstrb[0]) begin
                        next_state.ch[CH_FB].marker_flag_enable = pwdata[0];
                    end
                end
                ADDR_REF_FREEZE_ENABLE: begin
                    if (pstrb[0]) begin
                        next_state.ch[CH_REF].freeze_enable = pwdata[0];
                    end
                end
                ADDR_FB_FREEZE_ENABLE: begin
                    if (pstrb[0]) begin
                        next_state.ch[CH_FB].freeze_enable = pwdata[0];
                    end
                end
                ADDR_IRQ_STATUS: begin
                    if (pstrb[0]) begin
                        next_state.irq_status = state.irq_status
                                              & ~pwdata[IRQ_W-1:0];
                    end
                end
                ADDR_IRQ_MASK: begin
                    mask_word = byte_merge(
                        {{(32-IRQ_W){1'b0}}, state.irq_mask},
                        pwdata, pstrb);
                    next_state.irq_mask = mask_word[IRQ_W-1:0];
                end
                // Capture words are read-only; writes are dropped
                ADDR_REF_MARKER_CAPTURE_WORD,
                ADDR_FB_MARKER_CAPTURE_WORD,
                ADDR_REF_FREEZE_CAPTURE_WORD,
                ADDR_FB_FREEZE_CAPTURE_WORD: begin // R2
                    addr_ok = 1'b1;
                end
                default: begin
                    addr_ok = 1'b0;
                end
            endcase
        end

        // ------------------------------------------------------------------
        // Register decode, done in the setup cycle
        // ------------------------------------------------------------------
        if (setup_en) begin
            unique case (paddr)
                ADDR_REF_MARKER_CAPTURE_WORD:
                    rdata = state.ch[CH_REF].marker_word; // R2
                ADDR_FB_MARKER_CAPTURE_WORD:
                    rdata = state.ch[CH_FB].marker_word; // R2
                ADDR_REF_FREEZE_CAPTURE_WORD:
                    rdata = state.ch[CH_REF].freeze_word;
                ADDR_FB_FREEZE_CAPTURE_WORD:
                    rdata = state.ch[CH_FB].freeze_word;
                ADDR_REF_MARKER_FLAG:
                    rdata[0] = state.ch[CH_REF].marker_flag;
                ADDR_FB_MARKER_FLAG:
                    rdata[0] = state.ch[CH_FB].marker_flag;
                ADDR_REF_FREEZE_FLAG:
                    rdata[0] = state.ch[CH_REF].freeze_flag;
                ADDR_FB_FREEZE_FLAG:
                    rdata[0] = state.ch[CH_FB].freeze_flag;
                ADDR_REF_SOURCE_SELECT:
                    rdata[7:0] = state.ch[CH_REF].source_select;
                ADDR_FB_SOURCE_SELECT:
                    rdata[7:0] = state.ch[CH_FB].source_select;
                ADDR_REF_MARKER_FLAG_ENABLE:
                    rdata[0] = state.ch[CH_REF].marker_flag_enable;
                ADDR_FB_MARKER_FLAG_ENABLE:
                    rdata[0] = state.ch[CH_FB].marker_flag_enable;
                ADDR_REF_FREEZE_ENABLE:
                    rdata[0] = state.ch[CH_REF].freeze_enable;
                ADDR_FB_FREEZE_ENABLE:
                    rdata[0] = state.ch[CH_FB].freeze_enable;
                ADDR_IRQ_STATUS:
                    rdata[IRQ_W-1:0] = state.irq_status;
                ADDR_IRQ_MASK:
                    rdata[IRQ_W-1:0] = state.irq_mask;
                default:
                    addr_ok = 1'b0;
            endcase
        end

        // ------------------------------------------------------------------
        // Bus answer
        // ------------------------------------------------------------------
        // Latched in setup so data and error already stand at the edge
        // where the master first sees pready high; held through the
        // access phase, cleared once psel drops
        if (setup_en) begin
            next_state.resp.prdata  = pwrite ? RST_WORD : rdata;
            next_state.resp.pslverr = !addr_ok;
        end else if (!psel) begin
            next_state.resp.prdata  = RST_WORD;
            next_state.resp.pslverr = 1'b0;
        end

        // ------------------------------------------------------------------
        // Capture logic per channel
        // ------------------------------------------------------------------
        for (int c = 0; c < NUM_CH; c++) begin
            pos = select_position(state.ch[c].source_select,
                                  c == CH_REF ? ref_positions
                                              : fb_positions);
            // Flag clear first, so a same-cycle marker event wins; a freeze edge is gated by the old flag
            if (marker_clear[c]) begin
                next_state.ch[c].marker_flag = 1'b0; // R4
            end
            if (freeze_clear[c]) begin
                next_state.ch[c].freeze_flag = 1'b0; // R8
            end
            if (marker_edge[c]) begin
                next_state.ch[c].marker_word = pack_word(pos); // R1 R10
                if (state.ch[c].marker_flag_enable) begin
                    next_state.ch[c].marker_flag = 1'b1; // R3
                    events[IRQ_MARKER_LSB + c] = 1'b1;
                end
            end
            // Freeze is armed only while its flag reads zero
            if (freeze_edge[c] && !state.ch[c].freeze_flag) begin // R8
                next_state.ch[c].freeze_word = pack_word(pos); // R9 R10
                if (state.ch[c].freeze_enable) begin
                    next_state.ch[c].freeze_flag = 1'b1; // R7
                    events[IRQ_FREEZE_LSB + c] = 1'b1;
                end
            end
        end

        // Sticky status: set wins over write-one-to-clear
        next_state.irq_status = next_state.irq_status | events;
        next_state.irq = |(next_state.irq_status & next_state.irq_mask);
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int c = 0; c < NUM_CH; c++) begin
                state.ch[c].marker_word        <= RST_WORD;
                state.ch[c].freeze_word        <= RST_WORD;
                state.ch[c].marker_flag        <= 1'b0;
                state.ch[c].freeze_flag        <= 1'b0;
                state.ch[c].source_select      <= RST_SOURCE;
                state.ch[c].marker_flag_enable <= 1'b0;
                state.ch[c].freeze_enable      <= 1'b0;
                state.ch[c].marker_sync        <= 3'h0;
                state.ch[c].freeze_sync        <= 3'h0;
            end
            state.irq_status   <= '0;
            state.irq_mask     <= '0;
            state.resp.prdata  <= RST_WORD;
            state.resp.pready  <= 1'b0;
            state.resp.pslverr <= 1'b0;
            state.irq          <= 1'b0;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------------
    // Outputs, each straight from a state flop
    // ------------------------------------------------------------------
    assign prdata  = state.resp.prdata;
    assign pready  = state.resp.pready;
    assign pslverr = state.resp.pslverr;
    assign irq     = state.irq;

endmodule

`default_nettype wire

// ==== shared/encoder_capture_pkg.sv ====
// Package: register map, field layout and types of the encoder capture block
package encoder_capture_pkg;

    // Register byte offsets (APB, one aligned 32-bit word each)
    localparam logic [7:0] ADDR_REF_MARKER_CAPTURE_WORD = 8'h00;
    localparam logic [7:0] ADDR_FB_MARKER_CAPTURE_WORD  = 8'h04;
    localparam logic [7:0] ADDR_REF_FREEZE_CAPTURE_WORD = 8'h08;
    localparam logic [7:0] ADDR_FB_FREEZE_CAPTURE_WORD  = 8'h0c;
    localparam logic [7:0] ADDR_REF_MARKER_FLAG         = 8'h10;
    localparam logic [7:0] ADDR_FB_MARKER_FLAG          = 8'h14;
    localparam logic [7:0] ADDR_REF_FREEZE_FLAG         = 8'h18;
    localparam logic [7:0] ADDR_FB_FREEZE_FLAG          = 8'h1c;
    localparam logic [7:0] ADDR_REF_SOURCE_SELECT       = 8'h20;
    localparam logic [7:0] ADDR_FB_SOURCE_SELECT        = 8'h24;
    localparam logic [7:0] ADDR_REF_MARKER_FLAG_ENABLE  = 8'h28;
    localparam logic [7:0] ADDR_FB_MARKER_FLAG_ENABLE   = 8'h2c;
    localparam logic [7:0] ADDR_REF_FREEZE_ENABLE       = 8'h30;
    localparam logic [7:0] ADDR_FB_FREEZE_ENABLE        = 8'h34;
    localparam logic [7:0] ADDR_IRQ_STATUS              = 8'h38;
    localparam logic [7:0] ADDR_IRQ_MASK                = 8'h3c;

    // Capture word layout
    localparam int TURNS_LSB = 16;
    localparam int POS_W     = 16;

    // Channel indices
    localparam int CH_REF = 0;
    localparam int CH_FB  = 1;
    localparam int NUM_CH = 2;

    // Interrupt status bits: marker ref, marker fb, freeze ref, freeze fb
    localparam int IRQ_W          = 4;
    localparam int IRQ_MARKER_LSB = 0;
    localparam int IRQ_FREEZE_LSB = 2;

    // Reset values
    localparam logic [31:0] RST_WORD   = 32'h0000_0000;
    localparam logic [7:0]  RST_SOURCE = 8'h05;

    // Position source selector encoding
    typedef enum logic [7:0] {
        SRC_BASE_ENCODER = 8'h00,
        SRC_SLOT_1       = 8'h01,
        SRC_SLOT_2       = 8'h02,
        SRC_SLOT_3       = 8'h03,
        SRC_USER_PROGRAM = 8'h04,
        SRC_UNCONFIGURED = 8'h05
    } source_e;

    // One position sample: turns and coarse position
    typedef struct packed {
        logic [15:0] turns;
        logic [15:0] coarse;
    } position_s;

    // All positions offered to one channel
    typedef struct packed {
        position_s user_program;
        position_s slot_3;
        position_s slot_2;
        position_s slot_1;
        position_s base_encoder;
    } position_set_s;

    // Per-channel state
    typedef struct packed {
        logic [31:0] marker_word;
        logic [31:0] freeze_word;
        logic        marker_flag;
        logic        freeze_flag;
        logic [7:0]  source_select;
        logic        marker_flag_enable;
        logic        freeze_enable;
        logic [2:0]  marker_sync;
        logic [2:0]  freeze_sync;
    } channel_s;

    // APB answer
    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } apb_resp_s;

endpackage

// ==== test/encoder_capture_checker.sv ====
// Concurrent checks on the capture block's bus and interrupt ports
`timescale 1ns/100ps
`default_nettype none
module encoder_capture_checker
    import encoder_capture_pkg::*;
(
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [7:0]        paddr,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic [NUM_CH-1:0] marker_pulse,
    input wire logic [NUM_CH-1:0] freeze_input,
    input wire logic              irq
);
    // ----------------------------------------
    // Cycles since the last event input edge
    // ----------------------------------------
    logic [3:0]        age;
    logic [NUM_CH-1:0] mark_q;
    logic [NUM_CH-1:0] frz_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            age    <= 4'hf;
            mark_q <= '0;
            frz_q  <= '0;
        end else begin
            mark_q <= marker_pulse;
            frz_q  <= freeze_input;
            if (((marker_pulse & ~mark_q) | (freeze_input & ~frz_q)) != 0)
                age <= 4'h0;
            else if (age != 4'hf)
                age <= age + 4'h1;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_done;
        psel && penable && pready;
    endsequence
    a_ready_setup: assert property (s_setup |=> pready)
        else $error("no answer one cycle after setup");
    a_ready_early: assert property ($rose(psel) |-> !pready)
        else $error("answer present in setup cycle");
    a_ready_sel: assert property (pready |-> $past(psel))
        else $error("answer without a selected transfer");
    a_ready_drop: assert property (!psel |=> !pready)
        else $error("answer held after deselect");
    a_err_unmapped: assert property ((s_setup ##1 s_done) |->
        pslverr == (paddr > ADDR_IRQ_MASK || paddr[1:0] != 2'b00))
        else $error("error response does not match address");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("error response without answer");
    a_irq_cause: assert property ($rose(irq) |->
        age < 4'h8 || $past(psel && penable && pwrite))
        else $error("interrupt rose with no event or mask write");
    a_irq_clear: assert property ($fell(irq) |->
        $past(psel && penable && pwrite))
        else $error("interrupt fell without a write");
endmodule
`default_nettype wire

// ==== test/encoder_partner.sv ====
// Encoder model: positions per source and marker and freeze strobes
`timescale 1ns/100ps
`default_nettype none
module encoder_partner
    import encoder_capture_pkg::*;
(
    input  wire logic            pclk,
    output var position_set_s    ref_positions,
    output var position_set_s    fb_positions,
    output logic [NUM_CH-1:0]    marker_pulse,
    output logic [NUM_CH-1:0]    freeze_input
);
    logic [7:0] step = 8'h80;
    initial begin
        marker_pulse = '0;
        freeze_input = '0;
    end
    // Every channel and source differs, so a wrong mux shows at once
    function automatic logic [31:0] pos_of(input int c, input int s,
                                           input logic [7:0] k);
        return {k, 4'(c), 4'(s), 8'h5a, k ^ 8'(s)};
    endfunction
    always_comb begin
        for (int s = 0; s < 5; s++) begin
            ref_positions[s*32 +: 32] = pos_of(0, s, step);
            fb_positions[s*32 +: 32]  = pos_of(1, s, step);
        end
    end
    // Line held for four cycles so it clears the input synchroniser
    task automatic strobe(input bit frz, input int ch);
        @(posedge pclk);
        step <= step + 8'h13;
        if (frz)
            freeze_input[ch] <= 1'b1;
        else
            marker_pulse[ch] <= 1'b1;
        repeat (4) @(posedge pclk);
        freeze_input <= '0;
        marker_pulse <= '0;
        repeat (6) @(posedge pclk);
    endtask
endmodule
`default_nettype wire

// ==== test/tb_top.sv ====
// Self-checking bench for the encoder capture block
`timescale 1ns/100ps
`default_nettype none
module tb_top
    import encoder_capture_pkg::*;
;
    logic          pclk;
    logic          presetn;
    logic          psel;
    logic          penable;
    logic          pwrite;
    logic [7:0]    paddr;
    logic [31:0]   pwdata;
    logic [3:0]    pstrb;
    logic [31:0]   prdata;
    logic          pready;
    logic          pslverr;
    logic          irq;
    position_set_s ref_positions;
    position_set_s fb_positions;
    logic [1:0]    marker_pulse;
    logic [1:0]    freeze_input;
    logic [31:0]   rdat;
    logic          rerr;
    logic [31:0]   expw;
    int            n_fail = 0;
    int            check_count = 0;
    int            cycles = 0;
    encoder_marker_freeze_capture uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ref_positions(ref_positions), .fb_positions(fb_positions),
        .marker_pulse(marker_pulse), .freeze_input(freeze_input),
        .irq(irq));
    encoder_partner partner (
        .pclk(pclk), .ref_positions(ref_positions),
        .fb_positions(fb_positions), .marker_pulse(marker_pulse),
        .freeze_input(freeze_input));
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    task automatic chk(input string what, input logic [31:0] e,
                       input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask
    // Called just after a rising edge; returns just after one
    task automatic apb(input bit w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1)
            n_fail++;
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, rdat, rerr);
        chk($sformatf("reg %h", a), e, rdat);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, rdat, rerr);
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_fail++;
            summarize();
        end
    end
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        pstrb = 4'hf;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int a = 0; a < 64; a += 4)
            rd(8'(a), (a == 32 || a == 36) ? 32'h5 : 32'h0);
        apb(1'b0, 8'h40, 32'h0, rdat, rerr);
        chk("unmapped error", 32'h1, {31'h0, rerr});
        $display("test reset done");
        for (int c = 0; c < 2; c++) begin
            wr(8'(ADDR_REF_MARKER_FLAG_ENABLE + 4*c), 32'h1);
            for (int s = 0; s < 6; s++) begin
                wr(8'(ADDR_REF_SOURCE_SELECT + 4*c), 32'(s));
                wr(8'(ADDR_REF_MARKER_FLAG + 4*c), 32'h0);
                partner.strobe(1'b0, c);
                expw = s < 5 ? partner.pos_of(c, s, partner.step) : 32'h0;
                rd(8'(ADDR_REF_MARKER_CAPTURE_WORD + 4*c), expw);
                rd(8'(ADDR_REF_MARKER_FLAG + 4*c), 32'h1);
            end
        end
        wr(ADDR_REF_MARKER_FLAG_ENABLE, 32'h0);
        wr(ADDR_REF_SOURCE_SELECT, 32'h0);
        wr(ADDR_REF_MARKER_FLAG, 32'h0);
        partner.strobe(1'b0, 0);
        rd(ADDR_REF_MARKER_FLAG, 32'h0);
        wr(ADDR_REF_MARKER_FLAG, 32'h1);
        rd(ADDR_REF_MARKER_FLAG, 32'h0);
        wr(ADDR_REF_MARKER_CAPTURE_WORD, 32'hffff_ffff);
        expw = partner.pos_of(0, 0, partner.step);
        rd(ADDR_REF_MARKER_CAPTURE_WORD, expw);
        $display("test marker done");
        for (int c = 0; c < 2; c++) begin
            wr(8'(ADDR_REF_FREEZE_ENABLE + 4*c), 32'h1);
            wr(8'(ADDR_REF_SOURCE_SELECT + 4*c), 32'(c + 1));
            partner.strobe(1'b1, c);
            expw = partner.pos_of(c, c + 1, partner.step);
            rd(8'(ADDR_REF_FREEZE_CAPTURE_WORD + 4*c), expw);
            rd(8'(ADDR_REF_FREEZE_FLAG + 4*c), 32'h1);
            partner.strobe(1'b1, c);
            rd(8'(ADDR_REF_FREEZE_CAPTURE_WORD + 4*c), expw);
            wr(8'(ADDR_REF_FREEZE_FLAG + 4*c), 32'h0);
            wr(8'(ADDR_REF_FREEZE_ENABLE + 4*c), 32'h0);
            partner.strobe(1'b1, c);
            rd(8'(ADDR_REF_FREEZE_FLAG + 4*c), 32'h0);
            expw = partner.pos_of(c, c + 1, partner.step);
            rd(8'(ADDR_REF_FREEZE_CAPTURE_WORD + 4*c), expw);
        end
        $display("test freeze done");
        wr(ADDR_IRQ_STATUS, 32'hf);
        wr(ADDR_IRQ_MASK, 32'h1);
        wr(ADDR_REF_MARKER_FLAG_ENABLE, 32'h1);
        wr(ADDR_FB_MARKER_FLAG, 32'h0);
        partner.strobe(1'b0, 1);
        chk("irq masked", 32'h0, {31'h0, irq});
        rd(ADDR_IRQ_STATUS, 32'h2);
        partner.strobe(1'b0, 0);
        chk("irq raised", 32'h1, {31'h0, irq});
        wr(ADDR_IRQ_STATUS, 32'h1);
        chk("irq cleared", 32'h0, {31'h0, irq});
        rd(ADDR_IRQ_STATUS, 32'h2);
        pstrb <= 4'h0;
        wr(ADDR_FB_MARKER_FLAG, 32'h0);
        pstrb <= 4'hf;
        rd(ADDR_FB_MARKER_FLAG, 32'h1);
        $display("test irq done");
        summarize();
    end
endmodule
bind encoder_marker_freeze_capture encoder_capture_checker chk_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr),
    .marker_pulse(marker_pulse), .freeze_input(freeze_input), .irq(irq));
`default_nettype wire
